// file: src/cmsc_pkg.sv
package cmsc_pkg;

   // Conversion modes selectable by software.
   typedef enum logic {CMSC_CONTINUOUS, CMSC_ONE_SHOT} cmsc_mode_t;

   // Filter paths.
   typedef enum logic [1:0] {CMSC_SINC5, CMSC_SINC3, CMSC_WIDEBAND} cmsc_filter_t;

   // Configuration presented by the control side.
   typedef struct packed {
      cmsc_mode_t mode;         // Requested conversion mode.
      cmsc_filter_t filter;     // Requested filter path.
      logic [15:0] ratePeriod;  // Result interval in clock cycles, minus one.
      logic [15:0] settleCount; // Filter settling in clock cycles.
      logic startEnable;        // General-purpose pin acts as START input.
      logic syncOutPosEdge;     // Restart output pulse aligned on the positive edge option.
   } cmsc_cfg_t;

   // Width of the cycle counters.
   localparam int CMSC_CNT_W = 16;
   // Added start-up latency of a one-shot conversion, in clock cycles.
   localparam logic [15:0] CMSC_START_LATENCY = 16'h0004;
   // Reset value of the result interval and settle counts.
   localparam logic [15:0] CMSC_RATE_RESET = 16'h0013;
   localparam logic [15:0] CMSC_SETTLE_RESET = 16'h0020;
   // Length of the restart output pulse in cycles.
   localparam logic [1:0] CMSC_SYNC_OUT_LEN = 2'h1;

endpackage

// file: src/cmsc_control.sv
`timescale 1ns/1ps

// Contract
// - Reset selects continuous conversion mode.
// - Continuous mode emits result every rate interval.
// - Wideband filter only in continuous mode.
// - One-shot restart edge sets output timing.
// - One-shot restart resets filter, clears valid.
// - Valid rises after full settling time.
// - One-shot stays quiet until next restart.
// - One-shot only with sinc5 or sinc3.
// - One-shot delay is settling plus start latency.
// - Sampled START pin makes aligned restart pulse.
// - Sync command makes local restart pulse.
// - Restart input sampled on rising clock.
// - Restart near valid edge may pass pulse.
// - Direct sync strobe leaves pin free.
// - Unsettled flag high until filter settles.
module cmsc_control (
   input wire logic clock,
   input wire logic srst,
   input wire cmsc_pkg::cmsc_cfg_t cfg,
   input wire logic syncIn,
   input wire logic startPin,
   input wire logic regRestart,
   input wire logic syncCommand,
   output logic resultValid,
   output logic syncOut,
   output logic filterUnsettled,
   output logic filterReset,
   output cmsc_pkg::cmsc_mode_t activeMode,
   output logic gpioFree,
   output logic cfgError
);

   // Sequencer states.
   typedef enum logic [1:0] {CMSC_RUN, CMSC_SETTLE, CMSC_IDLE} cmsc_state_t;

   // Complete state of the block in one record.
   typedef struct packed {
      cmsc_state_t state;
      cmsc_pkg::cmsc_mode_t mode;
      logic [15:0] count;
      logic syncMeta;
      logic syncSync;
      logic syncPrev;
      logic startMeta;
      logic startSync;
      logic startPrev;
      logic [1:0] outCount;
      logic valid;
      logic unsettled;
      logic filtReset;
      logic syncOut;
      logic gpioFree;
      logic cfgError;
   } cmsc_regs_t;

   cmsc_regs_t r_reg;  // Registered state.
   cmsc_regs_t r_next; // Next state.
   logic restartEdge;  // Rising edge of the restart input, or a register restart.
   logic startEdge;    // Rising edge of the synchronised START pin.
   logic badCombo;     // Filter not allowed with the requested mode.

   // Returns the settle plus start latency count for one-shot mode.
   function automatic logic [15:0] oneShotDelay(input logic [15:0] settle);
      oneShotDelay = 16'(settle + cmsc_pkg::CMSC_START_LATENCY);
   endfunction

   // Next-state logic for the whole block.
   always_comb begin
      r_next = r_reg;
      // Restart input and START pin are sampled through two flops each.
      r_next.syncMeta = syncIn;
      r_next.syncSync = r_reg.syncMeta;
      r_next.syncPrev = r_reg.syncSync;
      r_next.startMeta = startPin;
      r_next.startSync = r_reg.startMeta;
      r_next.startPrev = r_reg.startSync;
      // A result already on its way still leaves while a pin edge crosses the flops.
      restartEdge = (r_reg.syncSync & ~r_reg.syncPrev) | regRestart;
      startEdge = cfg.startEnable & r_reg.startSync & ~r_reg.startPrev;
      // One-shot with the wideband path is refused; continuous stays in force.
      badCombo = (cfg.mode == cmsc_pkg::CMSC_ONE_SHOT) &&
         (cfg.filter == cmsc_pkg::CMSC_WIDEBAND);
      r_next.cfgError = badCombo;
      r_next.gpioFree = ~cfg.startEnable;
      r_next.valid = 1'b0;
      r_next.filtReset = 1'b0;
      // Restart output pulse generation from START or the sync command.
      if (startEdge || syncCommand) begin
         r_next.outCount = cmsc_pkg::CMSC_SYNC_OUT_LEN;
      end else if (r_reg.outCount != 2'h0) begin
         r_next.outCount = 2'(r_reg.outCount - 2'h1);
      end
      r_next.syncOut = (startEdge || syncCommand) || (r_reg.outCount > 2'h1);
      if (restartEdge) begin
         // A restart resets the filter and applies the requested mode, or continuous when the combination is refused.
         r_next.mode = badCombo ? cmsc_pkg::CMSC_CONTINUOUS : cfg.mode;
         r_next.filtReset = 1'b1;
         r_next.unsettled = 1'b1;
         r_next.state = CMSC_SETTLE;
         r_next.count = (r_next.mode == cmsc_pkg::CMSC_ONE_SHOT) ?
            oneShotDelay(cfg.settleCount) : cfg.settleCount;
      end else begin
         case (r_reg.state)
            // Continuous conversion: one result each interval.
            CMSC_RUN: begin
               if (r_reg.count >= cfg.ratePeriod) begin
                  r_next.count = 16'h0000;
                  r_next.valid = 1'b1;
               end else begin
                  r_next.count = 16'(r_reg.count + 16'h0001);
               end
            end
            // Waiting for the filter to settle.
            CMSC_SETTLE: begin
               if (r_reg.count <= 16'h0001) begin
                  r_next.valid = 1'b1;
                  r_next.unsettled = 1'b0;
                  r_next.count = 16'h0000;
                  r_next.state = (r_reg.mode == cmsc_pkg::CMSC_ONE_SHOT) ?
                     CMSC_IDLE : CMSC_RUN;
               end else begin
                  r_next.count = 16'(r_reg.count - 16'h0001);
               end
            end
            // One-shot result delivered; wait for the next restart.
            CMSC_IDLE: begin
               r_next.count = 16'h0000;
            end
            default: begin
               r_next.state = CMSC_RUN;
            end
         endcase
      end
   end

   // State register with synchronous reset.
   always_ff @(posedge clock) begin
      if (srst) begin
         r_reg <= '0;
         r_reg.mode <= cmsc_pkg::CMSC_CONTINUOUS;
         // The filter flushes after reset, so no result leaves while it is unsettled.
         r_reg.state <= CMSC_SETTLE;
         r_reg.count <= cmsc_pkg::CMSC_SETTLE_RESET;
         r_reg.unsettled <= 1'b1;
         r_reg.gpioFree <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   // Outputs straight from flops.
   assign resultValid = r_reg.valid;
   assign syncOut = r_reg.syncOut;
   assign filterUnsettled = r_reg.unsettled;
   assign filterReset = r_reg.filtReset;
   assign activeMode = r_reg.mode;
   assign gpioFree = r_reg.gpioFree;
   assign cfgError = r_reg.cfgError;

   // Reset leaves the block in continuous mode.
   property p_reset_mode;
      @(posedge clock) srst |=> (activeMode == cmsc_pkg::CMSC_CONTINUOUS);
   endproperty
   a_reset_mode: assert property (p_reset_mode) else $error("mode not continuous");

   // Restart pulse clears valid and resets the filter next cycle.
   property p_restart;
      @(posedge clock) disable iff (srst) regRestart |=> (filterReset && !resultValid);
   endproperty
   a_restart: assert property (p_restart) else $error("restart not applied");

   // Unsettled flag rises with the filter reset.
   property p_unsettled;
      @(posedge clock) disable iff (srst) filterReset |-> filterUnsettled;
   endproperty
   a_unsettled: assert property (p_unsettled) else $error("flag not set");

   // A register restart requesting wideband one-shot leaves continuous mode active.
   property p_no_wide_oneshot;
      @(posedge clock) disable iff (srst)
         (regRestart && badCombo) |=> (activeMode == cmsc_pkg::CMSC_CONTINUOUS);
   endproperty
   a_no_wide_oneshot: assert property (p_no_wide_oneshot) else $error("wideband one-shot");

   // Valid implies filter settled.
   property p_valid_settled;
      @(posedge clock) disable iff (srst) resultValid |-> !filterUnsettled;
   endproperty
   a_valid_settled: assert property (p_valid_settled) else $error("valid while unsettled");

   // In idle no result appears without a restart.
   property p_idle_quiet;
      @(posedge clock) disable iff (srst)
         (r_reg.state == CMSC_IDLE && !restartEdge) |=> !resultValid;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("one-shot extra result");

   // Sync command yields restart output next cycle.
   property p_sync_cmd;
      @(posedge clock) disable iff (srst) syncCommand |=> syncOut;
   endproperty
   a_sync_cmd: assert property (p_sync_cmd) else $error("no sync out");

   // Pin edge reaches the filter reset after three flops, even for a one-cycle pulse.
   property p_pin_sample;
      @(posedge clock) disable iff (srst) $rose(syncIn) |-> ##3 filterReset;
   endproperty
   a_pin_sample: assert property (p_pin_sample) else $error("pin restart lost");

   // Main scenarios.
   c_oneshot: cover property (@(posedge clock) r_reg.state == CMSC_IDLE);
   c_cont_valid: cover property (@(posedge clock) resultValid && r_reg.state == CMSC_RUN);
   c_start: cover property (@(posedge clock) startEdge);

endmodule // cmsc_control

// file: testbench/cmsc_host_model.sv
`timescale 1ns/1ps
// Host side model: drives the restart pin on the clock and loops the restart output back.
module cmsc_host_model (
   input wire logic clock,
   input wire logic srst,
   input wire logic pulseReq,
   input wire logic syncOut,
   output logic syncIn
);
   logic bootDone_reg; // Power-up restart has been sent.
   // The pin changes only after a rising edge, so periodic restarts stay coherent.
   always_ff @(posedge clock) begin
      if (srst) begin
         syncIn <= 1'b0;
         bootDone_reg <= 1'b0;
      end else begin
         syncIn <= pulseReq | syncOut | !bootDone_reg;
         bootDone_reg <= 1'b1;
      end
   end
endmodule // cmsc_host_model

// file: testbench/cmsc_control_bench.sv
`timescale 1ns/1ps
// Self-checking bench for the conversion mode and restart control.
module cmsc_control_bench;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic startPin = 1'b0;
   logic regRestart = 1'b0;
   logic syncCommand = 1'b0;
   logic syncIn, resultValid, syncOut, filterUnsettled, filterReset, gpioFree, cfgError;
   cmsc_pkg::cmsc_mode_t activeMode;
   cmsc_pkg::cmsc_cfg_t cfg = '{cmsc_pkg::CMSC_CONTINUOUS, cmsc_pkg::CMSC_SINC5,
      16'h0009, 16'h0006, 1'b0, 1'b1};
   int num_errors = 0;
   int compares = 0;
   int cycles = 0;
   int n;
   cmsc_control u_dut (.clock(clock), .srst(srst), .cfg(cfg), .syncIn(syncIn),
      .startPin(startPin), .regRestart(regRestart), .syncCommand(syncCommand),
      .resultValid(resultValid), .syncOut(syncOut), .filterUnsettled(filterUnsettled),
      .filterReset(filterReset), .activeMode(activeMode), .gpioFree(gpioFree),
      .cfgError(cfgError));
   cmsc_host_model u_host (.clock(clock), .srst(srst), .pulseReq(1'b0), .syncOut(syncOut),
      .syncIn(syncIn));
   initial forever #25 clock = ~clock;
   // A hang is cut short by a cycle ceiling.
   always @(posedge clock) begin
      cycles++;
      if (cycles > 3000) begin
         num_errors++;
         results();
      end
   end
   task results();
      if (num_errors == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task tick();
      @(posedge clock);
      #2;
   endtask
   task check(string name, logic [15:0] exp, logic [15:0] got);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Counts cycles until a signal is high, giving lim+1 when it never comes.
   task automatic waitSig(ref logic s, input int lim, output int cnt);
      cnt = 0;
      while (s !== 1'b1 && cnt <= lim) begin
         tick();
         cnt++;
      end
   endtask
   // Register restart, then checks the filter reset and the delay to the result.
   task regRestartCheck(int expN);
      tick();
      regRestart = 1'b1;
      tick();
      regRestart = 1'b0;
      check("filterReset", 16'h0001, filterReset);
      check("unsettled", 16'h0001, filterUnsettled);
      waitSig(resultValid, 200, n);
      check("settleDelay", expN[15:0], n[15:0]);
      check("settled", 16'h0000, filterUnsettled);
   endtask
   task testReset();
      check("resetMode", cmsc_pkg::CMSC_CONTINUOUS, activeMode);
      check("resetGpio", 16'h0001, gpioFree);
      check("resetUnsettled", 16'h0001, filterUnsettled);
   endtask
   task testContinuous();
      waitSig(filterReset, 10, n);
      check("bootRestart", 16'h0001, filterReset);
      tick();
      waitSig(resultValid, 200, n);
      check("contFirst", 16'h0005, n[15:0]);
      tick();
      waitSig(resultValid, 200, n);
      check("contPeriod", 16'h0009, n[15:0]);
   endtask
   task testOneShot();
      cfg.mode = cmsc_pkg::CMSC_ONE_SHOT;
      regRestartCheck(10);
      check("oneShotMode", cmsc_pkg::CMSC_ONE_SHOT, activeMode);
      tick();
      waitSig(resultValid, 60, n);
      check("quietAfter", 16'h003d, n[15:0]);
   endtask
   task testWideband();
      cfg.mode = cmsc_pkg::CMSC_CONTINUOUS;
      cfg.filter = cmsc_pkg::CMSC_WIDEBAND;
      regRestartCheck(6);
      check("wbContError", 16'h0000, cfgError);
      check("wbContMode", cmsc_pkg::CMSC_CONTINUOUS, activeMode);
      cfg.mode = cmsc_pkg::CMSC_ONE_SHOT;
      regRestartCheck(6);
      check("cfgError", 16'h0001, cfgError);
      check("wbMode", cmsc_pkg::CMSC_CONTINUOUS, activeMode);
      cfg.filter = cmsc_pkg::CMSC_SINC3;
   endtask
   task testSync();
      tick();
      syncCommand = 1'b1;
      tick();
      syncCommand = 1'b0;
      waitSig(syncOut, 10, n);
      check("syncCmdOut", 16'h0001, syncOut);
      waitSig(filterReset, 10, n);
      check("loopRestart", 16'h0001, filterReset);
      check("sinc3Mode", cmsc_pkg::CMSC_ONE_SHOT, activeMode);
      cfg.startEnable = 1'b1;
      tick();
      tick();
      check("gpioTaken", 16'h0000, gpioFree);
      startPin = 1'b1;
      waitSig(syncOut, 10, n);
      check("startOut", 16'h0001, syncOut);
      startPin = 1'b0;
   endtask
   initial begin
      repeat (5) tick();
      testReset();
      srst = 1'b0;
      testContinuous();
      testOneShot();
      testWideband();
      testSync();
      results();
   end
endmodule // cmsc_control_bench
